// File: hdl/thfc_pkg.sv
// Constants, register map and carrier types for the transmit holdoff and frame counter.
// Assumes one system clock at 250 MHz shared by every module that uses it.
package thfc_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the monitor control bus
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_TRANSMIT_CONTROL = 8'hb0;
    localparam logic [7:0] ADDR_HOLDOFF_COUNT_LOW = 8'hb1;
    localparam logic [7:0] ADDR_HOLDOFF_COUNT_HIGH = 8'hb2;
    localparam logic [7:0] ADDR_SENT_FRAMES_LOW = 8'hb3;
    localparam logic [7:0] ADDR_SENT_FRAMES_HIGH = 8'hb4;
    localparam logic [7:0] ADDR_SCRATCH_BYTE = 8'hff;

    // ------------------------------------------------------------------
    // Field positions of the transmit control register
    // ------------------------------------------------------------------
    localparam int CTRL_PERMIT_BIT = 0;
    localparam int CTRL_HOLDOFF_EN_BIT = 1;
    localparam int CTRL_STATUS_BIT = 2;
    localparam int CTRL_HC_LSB = 3;
    localparam int CTRL_HC_MSB = 7;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int HOLDOFF_WIDTH = 21;
    localparam int FRAME_COUNT_WIDTH = 16;
    localparam logic [4:0] RESET_HC_LOW_BITS = 5'h00;
    localparam logic RESET_PERMIT = 1'b1;
    localparam logic RESET_HOLDOFF_EN = 1'b0;
    localparam logic [7:0] RESET_HOLDOFF_COUNT_LOW = 8'h01;
    localparam logic [7:0] RESET_HOLDOFF_COUNT_HIGH = 8'h00;
    localparam logic [7:0] RESET_SCRATCH = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------------
    // Dump-save commands carried in a correlator frame
    // ------------------------------------------------------------------
    localparam logic [2:0] LAST_DUMP_SAVE_CMD = 3'h2;
    localparam logic [2:0] SINGLE_DUMP_SAVE_CMD = 3'h5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam real CLOCK_MHZ = 250.0;
    localparam real HOLDOFF_STEP_US = 31.0303;
    localparam int HOLDOFF_STEP_CYCLES = int'(HOLDOFF_STEP_US * CLOCK_MHZ);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } thfc_req_type;

    typedef struct packed {
        logic valid;
        logic [2:0] cmd;
        logic frame_start;
    } thfc_cmd_type;

    typedef enum logic [1:0] {
        THFC_IDLE = 2'b00,
        THFC_RUN = 2'b01
    } thfc_timer_state_type;

endpackage : thfc_pkg

// File: hdl/thfc_holdoff_timer.sv
// Holdoff timer: a step prescaler and a tick down-counter.
// Assumes start and load come from logic on the same clock.
module thfc_holdoff_timer #(
    parameter int STEP_CYCLES = thfc_pkg::HOLDOFF_STEP_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Control
    input wire logic start_in,
    input wire logic [thfc_pkg::HOLDOFF_WIDTH-1:0] load_in,
    // Status
    output logic running_out
);

    localparam int PW = $clog2(STEP_CYCLES + 1);

    thfc_pkg::thfc_timer_state_type state, next_state;
    logic [PW-1:0] prescale, next_prescale;
    logic [thfc_pkg::HOLDOFF_WIDTH-1:0] ticks, next_ticks;
    logic step;

    assign step = (prescale == PW'(STEP_CYCLES - 1));

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_prescale = prescale;
        next_ticks = ticks;
        if (start_in) begin
            next_prescale = '0;
            next_ticks = load_in;
            next_state = (load_in == '0) ? thfc_pkg::THFC_IDLE : thfc_pkg::THFC_RUN;
        end else begin
            case (state)
                thfc_pkg::THFC_RUN: begin
                    next_prescale = step ? '0 : prescale + 1'b1;
                    if (step) begin
                        next_ticks = ticks - 1'b1;
                        if (ticks == 21'h000001) begin
                            next_state = thfc_pkg::THFC_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = thfc_pkg::THFC_IDLE;
                    next_prescale = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= thfc_pkg::THFC_IDLE;
            prescale <= '0;
            ticks <= '0;
        end else begin
            state <= next_state;
            prescale <= next_prescale;
            ticks <= next_ticks;
        end
    end

    assign running_out = (state == thfc_pkg::THFC_RUN);

endmodule : thfc_holdoff_timer

// File: hdl/thfc_frame_counter.sv
// Sent frame counter with snapshot and clear.
// Assumes frame and snapshot strobes are one-cycle pulses on the same clock.
module thfc_frame_counter (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Events
    input wire logic frame_in,
    input wire logic snap_in,
    // Values
    output logic [thfc_pkg::FRAME_COUNT_WIDTH-1:0] count_out,
    output logic [thfc_pkg::FRAME_COUNT_WIDTH-1:0] snapshot_out
);

    logic [thfc_pkg::FRAME_COUNT_WIDTH-1:0] count, next_count;
    logic [thfc_pkg::FRAME_COUNT_WIDTH-1:0] snapshot, next_snapshot;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_count = count + {15'h0000, frame_in};
        next_snapshot = snapshot;
        if (snap_in) begin
            next_snapshot = count;
            next_count = {15'h0000, frame_in};
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= '0;
            snapshot <= '0;
        end else begin
            count <= next_count;
            snapshot <= next_snapshot;
        end
    end

    assign count_out = count;
    assign snapshot_out = snapshot;

endmodule : thfc_frame_counter

// File: hdl/thfc_top.sv
// Transmit holdoff timer, sent frame counter and scratch register with their bus port.
// Assumes bus, command and frame inputs come from logic on the same 250 MHz clock.
//
// What this block does
// - Holdoff count is 21 bits, used when enabled.
// - One holdoff step lasts 31.0303 microseconds.
// - Count bytes reset to low 0x01, high 0x00.
// - Low count byte gives count bits 12..5.
// - High count byte gives count bits 20..13.
// - Count frames sent since last low byte read, 16 bits.
// - Low byte read snapshots, clears, returns low.
// - High byte read returns snapshot high byte.
// - High byte reads never touch counter or snapshot.
// - Scratch byte at 0xff, read/write, no function.
// - First dump-save command per frame starts holdoff.
// - Permit bit cleared blocks all transmission.
// - Control upper five bits are count bits 4..0.
// - Status bit shows transmission currently allowed.
module thfc_top #(
    parameter int STEP_CYCLES = thfc_pkg::HOLDOFF_STEP_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Register bus request
    input wire thfc_pkg::thfc_req_type bus_req_in,
    // Register bus answer
    output logic [7:0] bus_rdata_out,
    output logic bus_rvalid_out,
    // Correlator frame commands
    input wire thfc_pkg::thfc_cmd_type cmd_in,
    // Formatter side
    input wire logic frame_sent_in,
    output logic tx_allow_out
);

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic hits(input thfc_pkg::thfc_req_type r, input logic [7:0] a);
        hits = (r.addr == a);
    endfunction : hits

    function automatic logic is_dump_save(input logic [2:0] c);
        is_dump_save = (c == thfc_pkg::LAST_DUMP_SAVE_CMD) ||
                       (c == thfc_pkg::SINGLE_DUMP_SAVE_CMD);
    endfunction : is_dump_save

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    logic transmit_permit, next_transmit_permit;
    logic holdoff_en, next_holdoff_en;
    logic [4:0] hc_low_bits, next_hc_low_bits;
    logic [7:0] holdoff_count_low, next_holdoff_count_low;
    logic [7:0] holdoff_count_high, next_holdoff_count_high;
    logic [7:0] scratch_byte, next_scratch_byte;
    logic wr;

    assign wr = bus_req_in.wr;

    always_comb begin
        next_transmit_permit = transmit_permit;
        next_holdoff_en = holdoff_en;
        next_hc_low_bits = hc_low_bits;
        next_holdoff_count_low = holdoff_count_low;
        next_holdoff_count_high = holdoff_count_high;
        next_scratch_byte = scratch_byte;
        if (wr && hits(bus_req_in, thfc_pkg::ADDR_TRANSMIT_CONTROL)) begin
            next_transmit_permit = bus_req_in.wdata[thfc_pkg::CTRL_PERMIT_BIT];
            next_holdoff_en = bus_req_in.wdata[thfc_pkg::CTRL_HOLDOFF_EN_BIT];
            next_hc_low_bits = bus_req_in.wdata[thfc_pkg::CTRL_HC_MSB:thfc_pkg::CTRL_HC_LSB];
        end
        if (wr && hits(bus_req_in, thfc_pkg::ADDR_HOLDOFF_COUNT_LOW)) begin
            next_holdoff_count_low = bus_req_in.wdata;
        end
        if (wr && hits(bus_req_in, thfc_pkg::ADDR_HOLDOFF_COUNT_HIGH)) begin
            next_holdoff_count_high = bus_req_in.wdata;
        end
        if (wr && hits(bus_req_in, thfc_pkg::ADDR_SCRATCH_BYTE)) begin
            next_scratch_byte = bus_req_in.wdata;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            transmit_permit <= thfc_pkg::RESET_PERMIT;
            holdoff_en <= thfc_pkg::RESET_HOLDOFF_EN;
            hc_low_bits <= thfc_pkg::RESET_HC_LOW_BITS;
            holdoff_count_low <= thfc_pkg::RESET_HOLDOFF_COUNT_LOW;
            holdoff_count_high <= thfc_pkg::RESET_HOLDOFF_COUNT_HIGH;
            scratch_byte <= thfc_pkg::RESET_SCRATCH;
        end else begin
            transmit_permit <= next_transmit_permit;
            holdoff_en <= next_holdoff_en;
            hc_low_bits <= next_hc_low_bits;
            holdoff_count_low <= next_holdoff_count_low;
            holdoff_count_high <= next_holdoff_count_high;
            scratch_byte <= next_scratch_byte;
        end
    end

    // ------------------------------------------------------------------
    // Holdoff start detection
    // ------------------------------------------------------------------
    logic [thfc_pkg::HOLDOFF_WIDTH-1:0] holdoff_count;
    logic seen_in_frame, next_seen_in_frame;
    logic seen_before;
    logic holdoff_start;
    logic holdoff_running;

    // Bits 20..13 high byte, 12..5 low byte, 4..0 from control.
    assign holdoff_count = {holdoff_count_high, holdoff_count_low, hc_low_bits};

    // A new frame forgets any command seen in the previous one.
    assign seen_before = seen_in_frame && !cmd_in.frame_start;
    assign holdoff_start = holdoff_en && cmd_in.valid && is_dump_save(cmd_in.cmd) &&
                           !seen_before;

    always_comb begin
        next_seen_in_frame = seen_before;
        if (cmd_in.valid && is_dump_save(cmd_in.cmd)) begin
            next_seen_in_frame = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            seen_in_frame <= 1'b0;
        end else begin
            seen_in_frame <= next_seen_in_frame;
        end
    end

    thfc_holdoff_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(holdoff_start),
        .load_in(holdoff_count),
        .running_out(holdoff_running)
    );

    // ------------------------------------------------------------------
    // Transmit permission
    // ------------------------------------------------------------------
    logic next_tx_allow;

    always_comb begin
        next_tx_allow = transmit_permit && !(holdoff_en && holdoff_running);
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_allow_out <= 1'b0;
        end else begin
            tx_allow_out <= next_tx_allow;
        end
    end

    // ------------------------------------------------------------------
    // Sent frame counter
    // ------------------------------------------------------------------
    logic rd;
    logic snap;
    logic [thfc_pkg::FRAME_COUNT_WIDTH-1:0] frame_count;
    logic [thfc_pkg::FRAME_COUNT_WIDTH-1:0] frame_snapshot;

    assign rd = bus_req_in.rd && !bus_req_in.wr;
    assign snap = rd && hits(bus_req_in, thfc_pkg::ADDR_SENT_FRAMES_LOW);

    thfc_frame_counter u_frames (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .frame_in(frame_sent_in),
        .snap_in(snap),
        .count_out(frame_count),
        .snapshot_out(frame_snapshot)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;
    logic [7:0] control_view;

    assign control_view = {hc_low_bits, next_tx_allow, holdoff_en, transmit_permit};

    always_comb begin
        case (bus_req_in.addr)
            thfc_pkg::ADDR_TRANSMIT_CONTROL: next_rdata = control_view;
            thfc_pkg::ADDR_HOLDOFF_COUNT_LOW: next_rdata = holdoff_count_low;
            thfc_pkg::ADDR_HOLDOFF_COUNT_HIGH: next_rdata = holdoff_count_high;
            thfc_pkg::ADDR_SENT_FRAMES_LOW: next_rdata = frame_count[7:0];
            thfc_pkg::ADDR_SENT_FRAMES_HIGH: next_rdata = frame_snapshot[15:8];
            thfc_pkg::ADDR_SCRATCH_BYTE: next_rdata = scratch_byte;
            default: next_rdata = thfc_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_rdata_out <= 8'h00;
            bus_rvalid_out <= 1'b0;
        end else begin
            bus_rdata_out <= rd ? next_rdata : 8'h00;
            bus_rvalid_out <= rd;
        end
    end

endmodule : thfc_top

// File: tb/thfc_top_checker.sv
// Concurrent checks on the ports of the holdoff timer and sent frame counter block.
// Assumes one clock and the asynchronous active-high reset of the block.
module thfc_top_checker #(
    parameter int STEP_CYCLES = thfc_pkg::HOLDOFF_STEP_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Register bus
    input wire thfc_pkg::thfc_req_type bus_req_in,
    input wire logic [7:0] bus_rdata_out,
    input wire logic bus_rvalid_out,
    // Commands and formatter side
    input wire thfc_pkg::thfc_cmd_type cmd_in,
    input wire logic frame_sent_in,
    input wire logic tx_allow_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rd_any;
    logic rd_lo;
    logic rd_hi;
    logic rd_ctl;
    logic rd_scr;
    logic wr_ctl;
    logic wr_scr;
    assign rd_any = bus_req_in.rd && !bus_req_in.wr;
    assign rd_lo = rd_any && bus_req_in.addr == thfc_pkg::ADDR_SENT_FRAMES_LOW;
    assign rd_hi = rd_any && bus_req_in.addr == thfc_pkg::ADDR_SENT_FRAMES_HIGH;
    assign rd_ctl = rd_any && bus_req_in.addr == thfc_pkg::ADDR_TRANSMIT_CONTROL;
    assign rd_scr = rd_any && bus_req_in.addr == thfc_pkg::ADDR_SCRATCH_BYTE;
    assign wr_ctl = bus_req_in.wr && bus_req_in.addr == thfc_pkg::ADDR_TRANSMIT_CONTROL;
    assign wr_scr = bus_req_in.wr && bus_req_in.addr == thfc_pkg::ADDR_SCRATCH_BYTE;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    a_read_answered: assert property (rd_any |=> bus_rvalid_out)
        else $error("read not answered one cycle later");
    a_idle_quiet: assert property (!rd_any |=> !bus_rvalid_out && bus_rdata_out == 8'h00)
        else $error("answer without a read");
    a_scratch_echo: assert property (wr_scr ##1 rd_scr |=>
        bus_rdata_out == $past(bus_req_in.wdata, 2)) else $error("scratch byte lost");
    a_high_repeat: assert property (rd_hi ##1 rd_hi |=>
        bus_rdata_out == $past(bus_rdata_out)) else $error("high byte changed on reread");
    a_low_clears: assert property (rd_lo && !frame_sent_in ##1 rd_lo |=>
        bus_rdata_out == 8'h00) else $error("low byte read did not clear");
    a_frame_carry: assert property (rd_lo && frame_sent_in ##1 rd_lo |=>
        bus_rdata_out == 8'h01) else $error("frame lost at clearing read");
    a_permit_blocks: assert property (wr_ctl && !bus_req_in.wdata[0] ##1 !wr_ctl |=>
        !tx_allow_out) else $error("transmit allowed with permit off");
    a_holdoff_off: assert property (wr_ctl && bus_req_in.wdata[1:0] == 2'b01 ##1 !wr_ctl
        |=> tx_allow_out) else $error("transmit blocked with holdoff off");
    a_status_tracks: assert property (rd_ctl |=> bus_rdata_out[2] == tx_allow_out)
        else $error("status bit differs from transmit allow");
endmodule : thfc_top_checker

bind thfc_top thfc_top_checker #(.STEP_CYCLES(STEP_CYCLES)) u_checker (
    .mclk_in(mclk_in), .rst_in(rst_in), .bus_req_in(bus_req_in),
    .bus_rdata_out(bus_rdata_out), .bus_rvalid_out(bus_rvalid_out), .cmd_in(cmd_in),
    .frame_sent_in(frame_sent_in), .tx_allow_out(tx_allow_out));

// File: tb/thfc_formatter_model.sv
// Downstream formatter model: sends one frame per cycle while asked and allowed.
// Assumes the go request comes from the bench on the same clock.
module thfc_formatter_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Bench control
    input wire logic go_in,
    // Block side
    input wire logic tx_allow_in,
    output logic frame_sent_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic next_frame_sent;
    always_comb begin
        next_frame_sent = go_in && tx_allow_in;
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_sent_out <= 1'b0;
        end else begin
            frame_sent_out <= next_frame_sent;
        end
    end
endmodule : thfc_formatter_model

// File: tb/tb.sv
// Self-checking bench for the holdoff timer and sent frame counter block.
// Assumes a short holdoff step so long counts run in few cycles.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STEP = 4;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    thfc_pkg::thfc_req_type req = '0;
    thfc_pkg::thfc_cmd_type cmd = '0;
    logic go = 1'b0;
    logic frame_sent;
    logic [7:0] rdata;
    logic rvalid;
    logic tx_allow;
    logic [7:0] raddr [6] = '{8'hb0, 8'hb1, 8'hb2, 8'hff, 8'hb3, 8'hb4};
    logic [7:0] rexp [6] = '{8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    int n_mismatch = 0;
    int checks = 0;
    always #2 mclk_in = ~mclk_in;
    thfc_top #(.STEP_CYCLES(STEP)) dut (.mclk_in(mclk_in), .rst_in(rst_in), .bus_req_in(req),
        .bus_rdata_out(rdata), .bus_rvalid_out(rvalid), .cmd_in(cmd),
        .frame_sent_in(frame_sent), .tx_allow_out(tx_allow));
    thfc_formatter_model partner (.mclk_in(mclk_in), .rst_in(rst_in), .go_in(go),
        .tx_allow_in(tx_allow), .frame_sent_out(frame_sent));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic step();
        @(posedge mclk_in);
        #1;
    endtask : step
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        step();
        chk({15'h0000, rvalid}, 16'h0001, "read valid");
        chk({8'h00, rdata & mask}, {8'h00, exp & mask}, "read data");
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step();
    endtask : wr
    task automatic idle();
        req = '0;
        step();
    endtask : idle
    task automatic frames(input int n);
        go = 1'b1;
        repeat (n) step();
        go = 1'b0;
        step();
        step();
    endtask : frames
    task automatic holdoff(input logic [2:0] code, input logic fs, input int lo, input int hi);
        int n_low;
        int n;
        n_low = 0;
        cmd = '{valid: 1'b1, cmd: code, frame_start: fs};
        step();
        cmd = '0;
        for (n = 0; n < hi + 8 && !(n_low > 0 && tx_allow === 1'b1); n++) begin
            step();
            if (tx_allow !== 1'b1) begin
                n_low++;
            end
        end
        chk(16'(n_low >= lo && n_low <= hi), 16'h0001, "holdoff length");
    endtask : holdoff
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk_in);
        #1;
        rst_in = 1'b0;
        step();
        for (int i = 0; i < 6; i++) begin
            rd(raddr[i], rexp[i], 8'hff);
        end
        wr(8'hff, 8'ha5);
        rd(8'hff, 8'ha5, 8'hff);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00, 8'hff);
        wr(8'hb0, 8'h00);
        idle();
        rd(8'hb0, 8'h00, 8'hff);
        chk({15'h0000, tx_allow}, 16'h0000, "transmit allow");
        frames(5);
        wr(8'hb0, 8'h01);
        idle();
        frames(259);
        rd(8'hb3, 8'h03, 8'hff);
        rd(8'hb4, 8'h01, 8'hff);
        rd(8'hb4, 8'h01, 8'hff);
        rd(8'hb3, 8'h00, 8'hff);
        rd(8'hb3, 8'h00, 8'hff);
        go = 1'b1;
        step();
        step();
        rd(8'hb3, 8'h00, 8'h00);
        rd(8'hb3, 8'h01, 8'hff);
        go = 1'b0;
        idle();
        wr(8'hb1, 8'h00);
        wr(8'hb0, 8'h1b);
        idle();
        holdoff(3'h2, 1'b1, 3 * STEP, 3 * STEP + 2);
        holdoff(3'h5, 1'b0, 0, 0);
        holdoff(3'h3, 1'b1, 0, 0);
        holdoff(3'h5, 1'b1, 3 * STEP, 3 * STEP + 2);
        wr(8'hb0, 8'h19);
        idle();
        holdoff(3'h2, 1'b1, 0, 0);
        wr(8'hb1, 8'h01);
        wr(8'hb0, 8'h03);
        idle();
        holdoff(3'h2, 1'b1, 32 * STEP, 32 * STEP + 2);
        wr(8'hb0, 8'h01);
        wr(8'hb1, 8'h00);
        wr(8'hb2, 8'h01);
        wr(8'hb0, 8'h03);
        idle();
        holdoff(3'h5, 1'b1, 8192 * STEP, 8192 * STEP + 2);
        tally_and_finish();
    end
    initial begin
        #(60000 * 4);
        n_mismatch++;
        $display("BAD t=%0t run did not complete", $time);
        tally_and_finish();
    end
endmodule : tb
